// file: rtl/irq_ctrl_pkg.sv
// Package: register map, reset values, vectors and carrier structs of the interrupt front end
package irq_ctrl_pkg;
   // -------------------------------------------------------------
   // Register indexes (byte address is four times the index)
   // -------------------------------------------------------------
   localparam logic [15:0] WAKE_EDGE_IDX = 16'hff90;
   localparam logic [15:0] EDGE_SEL_IDX  = 16'hfff2;
   localparam logic [15:0] EN_ONE_IDX    = 16'hfff3;
   localparam logic [15:0] EN_TWO_IDX    = 16'hfff4;
   localparam logic [15:0] REQ_ONE_IDX   = 16'hfff6;
   localparam logic [15:0] REQ_TWO_IDX   = 16'hfff7;
   localparam logic [15:0] WAKE_REQ_IDX  = 16'hfff9;
   localparam logic [15:0] EVT_STAT_IDX  = 16'hff80;
   localparam logic [15:0] EVT_MASK_IDX  = 16'hff81;
   // -------------------------------------------------------------
   // Reset values and fixed bits
   // -------------------------------------------------------------
   localparam logic [7:0] WAKE_EDGE_RST = 8'h00;
   localparam logic [7:0] EDGE_SEL_RST  = 8'he0;
   localparam logic [7:0] EDGE_SEL_FIX  = 8'he0;
   localparam logic [7:0] EN_ONE_RST    = 8'h00;
   localparam logic [7:0] EN_TWO_RST    = 8'h00;
   localparam logic [7:0] REQ_ONE_RST   = 8'h20;
   localparam logic [7:0] REQ_ONE_FIX   = 8'h20;
   localparam logic [7:0] REQ_TWO_RST   = 8'h00;
   localparam logic [7:0] WAKE_REQ_RST  = 8'h00;
   localparam logic [3:0] EVT_RST       = 4'h0;
   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int TIMER_A_BIT   = 7;
   localparam int SPARE_ONE_BIT = 6;
   localparam int WAKE_EN_BIT   = 5;
   localparam int SPARE_TWO_BIT = 5;
   localparam int EXT_PINS      = 5;
   localparam int WAKE_PINS     = 8;
   // -------------------------------------------------------------
   // Vector numbers; 1 to 3 and 10 are reserved and never issued
   // -------------------------------------------------------------
   localparam logic [4:0] VEC_EXT0    = 5'h04;
   localparam logic [4:0] VEC_WAKE    = 5'h09;
   localparam logic [4:0] VEC_TIMER_A = 5'h0b;
   localparam logic [4:0] VEC_NONE    = 5'h00;
   // Vector of second request register bits 0..7 (bit 5 has no source)
   localparam logic [4:0] VEC_TWO [8] = '{5'h0c, 5'h0d, 5'h0e, 5'h0f,
                                          5'h10, 5'h00, 5'h13, 5'h14};
   // -------------------------------------------------------------
   // Carriers
   // -------------------------------------------------------------
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [17:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;
   typedef struct packed {
      logic       valid;
      logic [4:0] vector;
   } cpu_req_s;
endpackage

// file: rtl/irq_edge_enable_control.sv
// Interrupt edge select, enable, request flags and priority front end with APB access
// Overview of operation
// R01 - Reserved vector slots 1 to 3 and 10 are never issued to the CPU.
// R02 - Request flags clear only by writing zero; writing one leaves them.
// R03 - Edge select bits 7 to 5 always read one and ignore writes.
// R04 - Edge select bit 4 sets pin 4 and converter trigger edge; 0 falling.
// R05 - Edge select bit 3 sets pin 3 and timer F event edge; 0 falling.
// R06 - Edge select bit 2 sets pin 2 edge only; 0 falling, 1 rising.
// R07 - Edge select bit 1 sets pin 1 and timer C event edge; 0 falling.
// R08 - Edge select bit 0 sets pin 0 edge only; 0 falling, 1 rising.
// R09 - Enable one bit 7 gates timer A overflow requests; reset blocks.
// R10 - Enable one bit 6 is plain storage, zero after reset.
// R11 - Enable one bit 5 gates all eight wakeup requests together.
// R12 - Enable one bits 4 to 0 gate external pins 4 to 0 each.
// R13 - Global mask set still lets flags set but no request is accepted.
// R14 - Flags are not cleared on acceptance; software writes zero.
// R15 - Among pending requests the lowest vector number goes first.
// R16 - A request needs its flag, its enable and a clear global mask.
// R17 - All mapped registers are eight bits wide; event status and event mask hold four bits, upper four read zero.
`timescale 1ns/1ns
module irq_edge_enable_control (
   input  wire logic                     core_clk,
   input  wire logic                     rst_n,
   input  wire logic                     ce,
   input  wire irq_ctrl_pkg::apb_req_s   apb_req,
   output logic                          pready,
   output logic [31:0]                   prdata,
   output logic                          pslverr,
   input  wire logic [4:0]               external_interrupt_pin,
   input  wire logic [7:0]               wakeup_pin,
   input  wire logic                     converter_trigger_pin,
   input  wire logic                     timer_f_event_pin,
   input  wire logic                     timer_c_event_pin,
   input  wire logic                     timer_a_overflow,
   input  wire logic [7:0]               periph_event,
   input  wire logic                     cpu_global_mask,
   output irq_ctrl_pkg::cpu_req_s        cpu_req,
   output logic                          converter_trigger_evt,
   output logic                          timer_f_evt,
   output logic                          timer_c_evt,
   output logic                          irq_out
);
   // -------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------
   logic [7:0] wake_edge_reg;
   logic [4:0] edge_sel_reg;
   logic [7:0] en_one_reg;
   logic [7:0] en_two_reg;
   logic [7:0] req_one_reg;
   logic [7:0] req_two_reg;
   logic [7:0] wake_req_reg;
   logic [3:0] evt_stat_reg;
   logic [3:0] evt_mask_reg;
   logic [4:0] ext_prev_reg;
   logic [7:0] wake_prev_reg;
   logic [2:0] shared_prev_reg;
   logic [4:0] ext_edge;
   logic [7:0] wake_edge;
   logic [15:0] idx;
   logic        addr_ok;
   logic        setup;
   logic        wr;
   logic [7:0]  wdat;
   logic [7:0]  rd_byte;
   logic        mapped;
   logic        req_one_we;
   logic        req_two_we;
   logic        wake_req_we;
   logic [7:0]  req_one_next;
   logic [7:0]  req_two_next;
   logic [7:0]  wake_req_next;
   logic [3:0]  evt_set;
   logic [4:0]  vec_next;
   logic        valid_next;
   logic [4:0]  ext_pend;
   logic        wake_pend;
   logic        ta_pend;
   logic [7:0]  two_pend;
   logic [2:0]  shared_pin;
   logic [2:0]  shared_sel;
   logic [2:0]  shared_edge;

   localparam logic [15:0] WAKE_EDGE_IDX_L = irq_ctrl_pkg::WAKE_EDGE_IDX;
   localparam logic [15:0] EDGE_SEL_IDX_L  = irq_ctrl_pkg::EDGE_SEL_IDX;
   localparam logic [15:0] EN_ONE_IDX_L    = irq_ctrl_pkg::EN_ONE_IDX;
   localparam logic [15:0] EN_TWO_IDX_L    = irq_ctrl_pkg::EN_TWO_IDX;
   localparam logic [15:0] REQ_ONE_IDX_L   = irq_ctrl_pkg::REQ_ONE_IDX;
   localparam logic [15:0] REQ_TWO_IDX_L   = irq_ctrl_pkg::REQ_TWO_IDX;
   localparam logic [15:0] WAKE_REQ_IDX_L  = irq_ctrl_pkg::WAKE_REQ_IDX;
   localparam logic [15:0] EVT_STAT_IDX_L  = irq_ctrl_pkg::EVT_STAT_IDX;
   localparam logic [15:0] EVT_MASK_IDX_L  = irq_ctrl_pkg::EVT_MASK_IDX;

   // -------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------
   assign idx     = apb_req.paddr[17:2];
   assign addr_ok = apb_req.paddr[1:0] == 2'h0;
   assign setup   = apb_req.psel && !apb_req.penable;
   // R17 eight bit data
   assign wdat    = apb_req.pwdata[7:0];
   assign wr      = apb_req.psel && apb_req.penable && pready && apb_req.pwrite
                    && !pslverr;

   always_comb begin
      rd_byte = 8'h00;
      mapped  = addr_ok;
      unique case (idx)
         WAKE_EDGE_IDX_L: rd_byte = wake_edge_reg;
         // R03 fixed ones
         EDGE_SEL_IDX_L:  rd_byte = irq_ctrl_pkg::EDGE_SEL_FIX | {3'h0, edge_sel_reg};
         EN_ONE_IDX_L:    rd_byte = en_one_reg;
         EN_TWO_IDX_L:    rd_byte = en_two_reg;
         REQ_ONE_IDX_L:   rd_byte = req_one_reg | irq_ctrl_pkg::REQ_ONE_FIX;
         REQ_TWO_IDX_L:   rd_byte = req_two_reg;
         WAKE_REQ_IDX_L:  rd_byte = wake_req_reg;
         EVT_STAT_IDX_L:  rd_byte = {4'h0, evt_stat_reg};
         EVT_MASK_IDX_L:  rd_byte = {4'h0, evt_mask_reg};
         default:         mapped  = 1'b0;
      endcase
   end

   // Answer one cycle after setup; unmapped or misaligned gives an error
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready  <= setup;
         pslverr <= setup && !mapped;
         if (setup && !apb_req.pwrite) begin
            prdata <= {24'h00_0000, mapped ? rd_byte : 8'h00};
         end
      end
   end

   // -------------------------------------------------------------
   // Plain control registers
   // -------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wake_edge_reg <= irq_ctrl_pkg::WAKE_EDGE_RST;
         edge_sel_reg  <= irq_ctrl_pkg::EDGE_SEL_RST[4:0];
         en_one_reg    <= irq_ctrl_pkg::EN_ONE_RST;
         en_two_reg    <= irq_ctrl_pkg::EN_TWO_RST;
         evt_mask_reg  <= irq_ctrl_pkg::EVT_RST;
      end else if (ce && wr) begin
         if (idx == WAKE_EDGE_IDX_L) begin
            wake_edge_reg <= wdat;
         end
         // R03 upper bits not stored
         if (idx == EDGE_SEL_IDX_L) begin
            edge_sel_reg <= wdat[4:0];
         end
         // R10 spare bit stored with the rest
         if (idx == EN_ONE_IDX_L) begin
            en_one_reg <= wdat;
         end
         if (idx == EN_TWO_IDX_L) begin
            en_two_reg <= wdat;
         end
         if (idx == EVT_MASK_IDX_L) begin
            evt_mask_reg <= wdat[3:0];
         end
      end
   end

   // -------------------------------------------------------------
   // Edge detection per pin
   // -------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < irq_ctrl_pkg::EXT_PINS; gi++) begin : g_ext
         // R04 R05 R06 R07 R08 one selects rising
         assign ext_edge[gi] = edge_sel_reg[gi]
            ? (external_interrupt_pin[gi] && !ext_prev_reg[gi])
            : (!external_interrupt_pin[gi] && ext_prev_reg[gi]);
      end
      for (gi = 0; gi < irq_ctrl_pkg::WAKE_PINS; gi++) begin : g_wake
         assign wake_edge[gi] = wake_edge_reg[gi]
            ? (wakeup_pin[gi] && !wake_prev_reg[gi])
            : (!wakeup_pin[gi] && wake_prev_reg[gi]);
      end
      for (gi = 0; gi < 3; gi++) begin : g_shared
         // R04 R05 R07 shared pins follow the same select
         assign shared_edge[gi] = shared_sel[gi]
            ? (shared_pin[gi] && !shared_prev_reg[gi])
            : (!shared_pin[gi] && shared_prev_reg[gi]);
      end
   endgenerate

   assign shared_pin = {converter_trigger_pin, timer_f_event_pin, timer_c_event_pin};
   assign shared_sel = {edge_sel_reg[4], edge_sel_reg[3], edge_sel_reg[1]};

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ext_prev_reg          <= 5'h1f;
         wake_prev_reg         <= 8'hff;
         shared_prev_reg       <= 3'h7;
         converter_trigger_evt <= 1'b0;
         timer_f_evt           <= 1'b0;
         timer_c_evt           <= 1'b0;
      end else if (ce) begin
         ext_prev_reg          <= external_interrupt_pin;
         wake_prev_reg         <= wakeup_pin;
         shared_prev_reg       <= shared_pin;
         converter_trigger_evt <= shared_edge[2];
         timer_f_evt           <= shared_edge[1];
         timer_c_evt           <= shared_edge[0];
      end
   end

   // -------------------------------------------------------------
   // Request flags: event set wins over a zero write
   // -------------------------------------------------------------
   assign req_one_we  = wr && idx == REQ_ONE_IDX_L;
   assign req_two_we  = wr && idx == REQ_TWO_IDX_L;
   assign wake_req_we = wr && idx == WAKE_REQ_IDX_L;

   always_comb begin
      req_one_next  = req_one_reg;
      req_two_next  = req_two_reg;
      wake_req_next = wake_req_reg;
      // R02 R14 only written zeros clear flags
      if (req_one_we) begin
         req_one_next = req_one_reg & wdat;
         req_one_next[irq_ctrl_pkg::SPARE_ONE_BIT] = wdat[irq_ctrl_pkg::SPARE_ONE_BIT];
      end
      if (req_two_we) begin
         req_two_next = req_two_reg & wdat;
         req_two_next[irq_ctrl_pkg::SPARE_TWO_BIT] = wdat[irq_ctrl_pkg::SPARE_TWO_BIT];
      end
      if (wake_req_we) begin
         wake_req_next = wake_req_reg & wdat;
      end
      // R13 flags set regardless of global mask
      req_one_next[4:0] = req_one_next[4:0] | ext_edge;
      req_one_next[irq_ctrl_pkg::TIMER_A_BIT] =
         req_one_next[irq_ctrl_pkg::TIMER_A_BIT] | timer_a_overflow;
      req_two_next  = req_two_next | (periph_event & 8'hdf);
      wake_req_next = wake_req_next | wake_edge;
      req_one_next[5] = 1'b0;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         req_one_reg  <= irq_ctrl_pkg::REQ_ONE_RST & ~irq_ctrl_pkg::REQ_ONE_FIX;
         req_two_reg  <= irq_ctrl_pkg::REQ_TWO_RST;
         wake_req_reg <= irq_ctrl_pkg::WAKE_REQ_RST;
      end else if (ce) begin
         req_one_reg  <= req_one_next;
         req_two_reg  <= req_two_next;
         wake_req_reg <= wake_req_next;
      end
   end

   // -------------------------------------------------------------
   // Event status (write one to clear) and interrupt line
   // -------------------------------------------------------------
   assign evt_set = {|(periph_event & 8'hdf), timer_a_overflow, |wake_edge, |ext_edge};

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         evt_stat_reg <= irq_ctrl_pkg::EVT_RST;
         irq_out      <= 1'b0;
      end else if (ce) begin
         if (wr && idx == EVT_STAT_IDX_L) begin
            evt_stat_reg <= (evt_stat_reg & ~wdat[3:0]) | evt_set;
         end else begin
            evt_stat_reg <= evt_stat_reg | evt_set;
         end
         irq_out <= |(evt_stat_reg & evt_mask_reg);
      end
   end

   // -------------------------------------------------------------
   // CPU request with fixed priority
   // -------------------------------------------------------------
   // R12 per pin gates
   assign ext_pend  = req_one_reg[4:0] & en_one_reg[4:0];
   // R11 one gate for the wakeup group
   assign wake_pend = |wake_req_reg && en_one_reg[irq_ctrl_pkg::WAKE_EN_BIT];
   // R09 timer A gate
   assign ta_pend   = req_one_reg[irq_ctrl_pkg::TIMER_A_BIT]
                      && en_one_reg[irq_ctrl_pkg::TIMER_A_BIT];
   assign two_pend  = req_two_reg & en_two_reg & 8'hdf;
   // R01 no source maps to a reserved slot

   always_comb begin
      vec_next = irq_ctrl_pkg::VEC_NONE;
      // R15 scan from lowest priority so the highest is written last
      for (int i = 7; i >= 0; i--) begin
         if (two_pend[i]) begin
            vec_next = irq_ctrl_pkg::VEC_TWO[i];
         end
      end
      if (ta_pend) begin
         vec_next = irq_ctrl_pkg::VEC_TIMER_A;
      end
      if (wake_pend) begin
         vec_next = irq_ctrl_pkg::VEC_WAKE;
      end
      for (int i = 4; i >= 0; i--) begin
         if (ext_pend[i]) begin
            vec_next = irq_ctrl_pkg::VEC_EXT0 + 5'(i);
         end
      end
      // R16 R13 global mask blocks acceptance
      valid_next = vec_next != irq_ctrl_pkg::VEC_NONE && !cpu_global_mask;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cpu_req <= '0;
      end else if (ce) begin
         cpu_req.valid  <= valid_next;
         cpu_req.vector <= valid_next ? vec_next : irq_ctrl_pkg::VEC_NONE;
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   a_reserved_vectors: assert property (@(posedge core_clk) disable iff (!rst_n) // R01
      cpu_req.valid |-> !(cpu_req.vector inside {5'h01, 5'h02, 5'h03, 5'h0a}))
      else $error("reserved vector issued");
   a_one_write_keeps: assert property (@(posedge core_clk) disable iff (!rst_n) // R02
      ce && req_one_we && req_one_reg[0] && wdat[0] |=> req_one_reg[0])
      else $error("writing one cleared a flag");
   a_edge_sel_ones: assert property (@(posedge core_clk) disable iff (!rst_n) // R03
      ce && setup && !apb_req.pwrite && idx == EDGE_SEL_IDX_L && addr_ok
      |=> prdata[7:5] == 3'h7)
      else $error("edge select upper bits not one");
   a_pin4_falling: assert property (@(posedge core_clk) disable iff (!rst_n) // R04
      ce && !edge_sel_reg[4] && $fell(external_interrupt_pin[4]) && !req_one_we
      |-> ##1 req_one_reg[4])
      else $error("falling edge on pin 4 missed");
   a_shared_trig: assert property (@(posedge core_clk) disable iff (!rst_n) // R05
      ce && edge_sel_reg[3] && $rose(timer_f_event_pin) |=> timer_f_evt)
      else $error("timer f rising edge missed");
   a_pin_rise_only: assert property (@(posedge core_clk) disable iff (!rst_n) // R06
      ce && edge_sel_reg[2] && !req_one_reg[2] && $fell(external_interrupt_pin[2])
      && !timer_a_overflow |=> !req_one_reg[2])
      else $error("falling edge set flag in rising mode");
   a_timer_a_gate: assert property (@(posedge core_clk) disable iff (!rst_n) // R09
      cpu_req.valid && cpu_req.vector == irq_ctrl_pkg::VEC_TIMER_A
      |-> $past(en_one_reg[irq_ctrl_pkg::TIMER_A_BIT]))
      else $error("timer A request without enable");
   a_wake_gate: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
      cpu_req.valid && cpu_req.vector == irq_ctrl_pkg::VEC_WAKE
      |-> $past(en_one_reg[irq_ctrl_pkg::WAKE_EN_BIT]))
      else $error("wakeup request without group enable");
   a_mask_blocks: assert property (@(posedge core_clk) disable iff (!rst_n) // R13
      ce && cpu_global_mask |=> !cpu_req.valid)
      else $error("request issued while masked");
   a_highest_first: assert property (@(posedge core_clk) disable iff (!rst_n) // R15
      ce && ext_pend[0] && !cpu_global_mask |=> cpu_req.valid
      && cpu_req.vector == irq_ctrl_pkg::VEC_EXT0)
      else $error("pin 0 not served first");
endmodule

// file: test/cpu_core_model.sv
// CPU core side: global mask bit and record of accepted interrupt vectors
`timescale 1ns/1ns
module cpu_core_model (
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   input  wire logic                   mask_in,
   input  wire irq_ctrl_pkg::cpu_req_s cpu_req,
   output logic                        cpu_global_mask,
   output logic [4:0]                  last_vec,
   output logic                        bad_vec
);
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         cpu_global_mask <= 1'b1;
      else
         cpu_global_mask <= mask_in;
   end
   // accept only unmasked, never clear flags, flag reserved slots
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         last_vec <= 5'h00;
         bad_vec  <= 1'b0;
      end else if (cpu_req.valid && !cpu_global_mask) begin
         last_vec <= cpu_req.vector;
         if (cpu_req.vector inside {5'h01, 5'h02, 5'h03, 5'h0a})
            bad_vec <= 1'b1;
      end
   end
endmodule

// file: test/irq_edge_enable_control_tb.sv
// Self-checking bench for the interrupt edge and enable front end
`timescale 1ns/1ns
module irq_edge_enable_control_tb;
   logic                   core_clk, rst_n, ce, mask_in, gmask, bad_vec, err;
   logic                   pready, pslverr, conv_evt, tf_evt, tc_evt, irq_out;
   logic                   conv_pin, tf_pin, tc_pin, ta_ovf;
   logic [31:0]            prdata;
   logic [4:0]             ext_pin, last_vec;
   logic [7:0]             wake_pin, periph, rd;
   irq_ctrl_pkg::apb_req_s req;
   irq_ctrl_pkg::cpu_req_s cpu_req;
   int                     error_cnt, n_compared;
   int                     pulse_cnt [3];

   irq_edge_enable_control uut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
      .apb_req(req), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .external_interrupt_pin(ext_pin), .wakeup_pin(wake_pin),
      .converter_trigger_pin(conv_pin), .timer_f_event_pin(tf_pin),
      .timer_c_event_pin(tc_pin), .timer_a_overflow(ta_ovf), .periph_event(periph),
      .cpu_global_mask(gmask), .cpu_req(cpu_req), .converter_trigger_evt(conv_evt),
      .timer_f_evt(tf_evt), .timer_c_evt(tc_evt), .irq_out(irq_out));
   cpu_core_model cpu (.core_clk(core_clk), .rst_n(rst_n), .mask_in(mask_in),
      .cpu_req(cpu_req), .cpu_global_mask(gmask), .last_vec(last_vec), .bad_vec(bad_vec));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (conv_evt === 1'b1) pulse_cnt[0]++;
      if (tf_evt === 1'b1) pulse_cnt[1]++;
      if (tc_evt === 1'b1) pulse_cnt[2]++;
   end
   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
      @(posedge core_clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00},
               pwdata: {24'h000000, wd}};
      @(posedge core_clk);
      req.penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask
   task automatic rdchk(input string what, input logic [15:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      check(what, {24'h000000, rd}, {24'h000000, exp});
   endtask
   task automatic drive(input int p, input logic v);
      @(posedge core_clk);
      ext_pin[p] <= v;
      if (p == 4) conv_pin <= v;
      if (p == 3) tf_pin <= v;
      if (p == 1) tc_pin <= v;
   endtask
   task automatic vec(input logic [5:0] exp);
      cyc(3);
      check("cpu_req", {26'h0, cpu_req}, {26'h0, exp});
   endtask
   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic test_reset;
      rdchk("wake_edge", irq_ctrl_pkg::WAKE_EDGE_IDX, 8'h00);
      rdchk("edge_sel", irq_ctrl_pkg::EDGE_SEL_IDX, 8'he0);
      rdchk("en_one", irq_ctrl_pkg::EN_ONE_IDX, 8'h00);
      rdchk("en_two", irq_ctrl_pkg::EN_TWO_IDX, 8'h00);
      rdchk("req_one", irq_ctrl_pkg::REQ_ONE_IDX, 8'h20);
      rdchk("req_two", irq_ctrl_pkg::REQ_TWO_IDX, 8'h00);
      rdchk("wake_req", irq_ctrl_pkg::WAKE_REQ_IDX, 8'h00);
      wr(irq_ctrl_pkg::EDGE_SEL_IDX, 8'h00);
      rdchk("edge_sel fixed", irq_ctrl_pkg::EDGE_SEL_IDX, 8'he0);
      wr(irq_ctrl_pkg::EN_ONE_IDX, 8'h40);
      rdchk("spare bit", irq_ctrl_pkg::EN_ONE_IDX, 8'h40);
      wr(irq_ctrl_pkg::EN_ONE_IDX, 8'h00);
      apb(1'b0, 16'h0001, 8'h00);
      check("unmapped", {23'h0, err, rd}, {23'h0, 1'b1, 8'h00});
      $display("test reset done");
   endtask
   task automatic test_edges;
      logic [7:0] b;
      for (int p = 0; p < 5; p++) begin
         b = 8'h01 << p;
         drive(p, 1'b0);
         rdchk("fall flag", irq_ctrl_pkg::REQ_ONE_IDX, 8'h20 | b);
         wr(irq_ctrl_pkg::REQ_ONE_IDX, 8'hff);
         rdchk("write one", irq_ctrl_pkg::REQ_ONE_IDX, 8'h60 | b);
         wr(irq_ctrl_pkg::REQ_ONE_IDX, 8'hbf & ~b);
         rdchk("write zero", irq_ctrl_pkg::REQ_ONE_IDX, 8'h20);
         drive(p, 1'b1);
         rdchk("rise ignored", irq_ctrl_pkg::REQ_ONE_IDX, 8'h20);
         wr(irq_ctrl_pkg::EDGE_SEL_IDX, b);
         rdchk("sel", irq_ctrl_pkg::EDGE_SEL_IDX, 8'he0 | b);
         drive(p, 1'b0);
         rdchk("fall ignored", irq_ctrl_pkg::REQ_ONE_IDX, 8'h20);
         drive(p, 1'b1);
         rdchk("rise flag", irq_ctrl_pkg::REQ_ONE_IDX, 8'h20 | b);
         wr(irq_ctrl_pkg::REQ_ONE_IDX, 8'ha0);
         wr(irq_ctrl_pkg::EDGE_SEL_IDX, 8'h00);
      end
      check("conv pulses", pulse_cnt[0], 2);
      check("timer f pulses", pulse_cnt[1], 2);
      check("timer c pulses", pulse_cnt[2], 2);
      $display("test edges done");
   endtask
   task automatic test_gating;
      drive(2, 1'b0);
      drive(0, 1'b0);
      vec(6'h00);
      wr(irq_ctrl_pkg::EN_ONE_IDX, 8'h04);
      vec({1'b1, 5'h06});
      wr(irq_ctrl_pkg::EN_ONE_IDX, 8'h05);
      vec({1'b1, 5'h04});
      mask_in <= 1'b1;
      drive(1, 1'b0);
      vec(6'h00);
      rdchk("masked flag", irq_ctrl_pkg::REQ_ONE_IDX, 8'h27);
      mask_in <= 1'b0;
      vec({1'b1, 5'h04});
      check("accepted", {27'h0, last_vec}, {27'h0, 5'h04});
      wr(irq_ctrl_pkg::REQ_ONE_IDX, 8'hbe);
      vec({1'b1, 5'h06});
      wr(irq_ctrl_pkg::REQ_ONE_IDX, 8'ha0);
      for (int p = 0; p < 3; p++) drive(p, 1'b1);
      @(posedge core_clk) ta_ovf <= 1'b1;
      @(posedge core_clk) ta_ovf <= 1'b0;
      vec(6'h00);
      wr(irq_ctrl_pkg::EN_ONE_IDX, 8'h80);
      vec({1'b1, 5'h0b});
      @(posedge core_clk) wake_pin[3] <= 1'b0;
      rdchk("wake flag", irq_ctrl_pkg::WAKE_REQ_IDX, 8'h08);
      vec({1'b1, 5'h0b});
      wr(irq_ctrl_pkg::EN_ONE_IDX, 8'ha0);
      vec({1'b1, 5'h09});
      check("reserved vector", {31'h0, bad_vec}, 32'h0);
      wr(irq_ctrl_pkg::WAKE_REQ_IDX, 8'h00);
      wr(irq_ctrl_pkg::REQ_ONE_IDX, 8'h20);
      wr(irq_ctrl_pkg::EN_ONE_IDX, 8'h00);
      vec(6'h00);
      $display("test gating done");
   endtask
   task automatic test_irq;
      wr(irq_ctrl_pkg::EVT_STAT_IDX, 8'h0f);
      rdchk("status clear", irq_ctrl_pkg::EVT_STAT_IDX, 8'h00);
      @(posedge core_clk) periph <= 8'h01;
      @(posedge core_clk) periph <= 8'h00;
      rdchk("status set", irq_ctrl_pkg::EVT_STAT_IDX, 8'h08);
      rdchk("req_two set", irq_ctrl_pkg::REQ_TWO_IDX, 8'h01);
      check("irq masked", {31'h0, irq_out}, 32'h0);
      wr(irq_ctrl_pkg::EVT_MASK_IDX, 8'h08);
      cyc(2);
      check("irq raised", {31'h0, irq_out}, 32'h1);
      wr(irq_ctrl_pkg::EVT_STAT_IDX, 8'h08);
      cyc(2);
      check("irq cleared", {31'h0, irq_out}, 32'h0);
      wr(irq_ctrl_pkg::REQ_TWO_IDX, 8'hff);
      rdchk("req_two keep", irq_ctrl_pkg::REQ_TWO_IDX, 8'h21);
      wr(irq_ctrl_pkg::REQ_TWO_IDX, 8'h00);
      rdchk("req_two clear", irq_ctrl_pkg::REQ_TWO_IDX, 8'h00);
      ce <= 1'b0;
      @(posedge core_clk) periph <= 8'h02;
      @(posedge core_clk) periph <= 8'h00;
      @(posedge core_clk) ce <= 1'b1;
      rdchk("frozen", irq_ctrl_pkg::REQ_TWO_IDX, 8'h00);
      $display("test irq done");
   endtask
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // -------------------------------------------------------------
   // Main sequence and watchdog
   // -------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      mask_in = 1'b0;
      req = '0;
      ext_pin = 5'h1f;
      wake_pin = 8'hff;
      periph = 8'h00;
      {conv_pin, tf_pin, tc_pin, ta_ovf} = 4'he;
      error_cnt = 0;
      n_compared = 0;
      pulse_cnt = '{0, 0, 0};
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      test_reset();
      test_edges();
      test_gating();
      test_irq();
      results();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      results();
   end
endmodule
